// ==== test/ctl_model.sv ====
// Motion controller model driving pulse and select pins
`timescale 1ns/100ps
module ctl_model (
  // Clock
  input wire logic core_clk_i,
  // Controller pins
  output logic pulse_o,
  output logic dir_o,
  output logic [5:0] sel_o,
  output logic trig_o
);
  initial begin
    pulse_o = 1'b0;
    dir_o = 1'b0;
    sel_o = 6'h00;
    trig_o = 1'b0;
  end
  // Pulses high three clocks, then low four clocks before the next pulse
  task send_pulses(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      pulse_o <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      pulse_o <= 1'b0;
      repeat (3) @(posedge core_clk_i);
    end
  endtask : send_pulses
  // Direction changed between pulses
  task set_dir(input logic d);
    @(posedge core_clk_i);
    dir_o <= d;
  endtask : set_dir
  // Select settled before the trigger edge
  task start_move(input logic [5:0] entry);
    @(posedge core_clk_i);
    sel_o <= entry;
    repeat (3) @(posedge core_clk_i);
    trig_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    trig_o <= 1'b0;
  endtask : start_move
endmodule : ctl_model

// ==== test/gear_chk.sv ====
// Assertion checker for the gear block ports
`timescale 1ns/100ps
module gear_chk (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Observed ports
  input wire gear_pkg::bus_req_type bus_i,
  input wire logic [31:0] rdata_o,
  input wire logic [31:0] motor_position_i,
  input wire logic command_trigger_input_i,
  input wire logic [31:0] position_command_o,
  input wire logic [31:0] smoothed_command_o,
  input wire gear_pkg::pos_status_type status_o,
  input wire logic irq_o
);
  logic trig_q;
  logic [7:0] trig_age;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Trigger age counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    trig_q <= command_trigger_input_i;
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      trig_age <= 8'hFF;
    end else if (command_trigger_input_i && !trig_q) begin
      trig_age <= 8'h00;
    end else if (trig_age != 8'hFF) begin
      trig_age <= trig_age + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_zero: assert property (disable iff (1'b0) rst_i |=> position_command_o == 32'h0
    && smoothed_command_o == 32'h0 && status_o == 3'h0 && irq_o == 1'b0)
    else $error("outputs not cleared by reset");
  a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_mc_both: assert property (status_o.motion_complete ==
    (status_o.cmd_done && status_o.target_reached)) else $error("motion complete mismatch");
  a_done_hold: assert property (status_o.cmd_done && $past(status_o.cmd_done)
    |-> $stable(position_command_o)) else $error("command moved while done");
  a_trig_clears: assert property ($rose(command_trigger_input_i)
    |-> ##[1:8] !status_o.cmd_done) else $error("trigger did not restart move");
  a_done_stands: assert property ($fell(status_o.cmd_done) |-> trig_age <= 8'h0A)
    else $error("done dropped without trigger");
  a_reach_in: assert property ((status_o.cmd_done
    && motor_position_i == position_command_o) [*3] |-> status_o.target_reached)
    else $error("target not reached at target");
  a_reach_out: assert property ((status_o.cmd_done && motor_position_i ==
    position_command_o - gear_pkg::BAND_RST - 32'h1) [*3] |-> !status_o.target_reached)
    else $error("target reached outside band");
endmodule : gear_chk
bind position_command_gear_and_status gear_chk u_gear_chk (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .motor_position_i(motor_position_i),
  .command_trigger_input_i(command_trigger_input_i), .position_command_o(position_command_o),
  .smoothed_command_o(smoothed_command_o), .status_o(status_o), .irq_o(irq_o));

// ==== test/tb.sv ====
// Self-checking testbench for the gear block
`timescale 1ns/100ps
module tb;
  logic core_clk_i;
  logic rst_i;
  gear_pkg::bus_req_type bus_i;
  logic [31:0] rdata_o;
  logic drive_enable_i;
  logic [31:0] motor_position_i;
  logic pulse_i;
  logic pulse_dir_i;
  logic [5:0] sel;
  logic trig;
  logic [31:0] position_command_o;
  logic [31:0] smoothed_command_o;
  gear_pkg::pos_status_type status_o;
  logic irq_o;
  logic [31:0] rd_val;
  int failures;
  int checks;
  position_command_gear_and_status u_position_command_gear_and_status (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .drive_enable_i(drive_enable_i), .motor_position_i(motor_position_i),
    .pulse_i(pulse_i), .pulse_dir_i(pulse_dir_i), .position_select_inputs_i(sel),
    .command_trigger_input_i(trig), .position_command_o(position_command_o),
    .smoothed_command_o(smoothed_command_o), .status_o(status_o), .irq_o(irq_o));
  ctl_model u_ctl_model (.core_clk_i(core_clk_i), .pulse_o(pulse_i), .dir_o(pulse_dir_i),
    .sel_o(sel), .trig_o(trig));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc
  task bw(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk_i);
    bus_i <= '0;
  endtask : bw
  task rchk(input string name, input logic [15:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    bus_i <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk_i);
    bus_i <= '0;
    #1;
    rd_val = rdata_o;
    chk(name, exp, rd_val);
  endtask : rchk
  task set_en(input logic v);
    @(posedge core_clk_i);
    drive_enable_i <= v;
  endtask : set_en
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset_values;
    rchk("num_first", gear_pkg::NUM_FIRST_OFS, gear_pkg::NUM_FIRST_RST);
    rchk("smoothing", gear_pkg::SMOOTH_OFS, 32'h0);
    rchk("unmapped", 16'h0010, 32'h0);
  endtask : t_reset_values
  task t_gear_access;
    set_en(1'b0);
    bw(gear_pkg::DENOM_OFS, 32'h3);
    rchk("denom", gear_pkg::DENOM_OFS, 32'h3);
    set_en(1'b1);
    bw(gear_pkg::DENOM_OFS, 32'h5);
    rchk("denom", gear_pkg::DENOM_OFS, 32'h3);
    bw(gear_pkg::NUM_FIRST_OFS, gear_pkg::NUM_MAX);
    rchk("num_first", gear_pkg::NUM_FIRST_OFS, gear_pkg::NUM_MAX);
    bw(gear_pkg::NUM_FIRST_OFS, 32'h2000_0000);
    rchk("num_first", gear_pkg::NUM_FIRST_OFS, gear_pkg::NUM_MAX);
    bw(gear_pkg::NUM_FIRST_OFS, 32'h2);
    set_en(1'b0);
    bw(gear_pkg::NUM_FIRST_OFS, 32'h7);
    rchk("num_first", gear_pkg::NUM_FIRST_OFS, 32'h2);
  endtask : t_gear_access
  task t_pulse_gear;
    u_ctl_model.send_pulses(3);
    cyc(4);
    chk("command", 32'h2, position_command_o);
    bw(gear_pkg::NUM_EXTRA0_OFS, 32'h3);
    bw(gear_pkg::CTRL_OFS, 32'h1);
    u_ctl_model.send_pulses(1);
    cyc(4);
    chk("command", 32'h3, position_command_o);
    u_ctl_model.set_dir(1'b1);
    u_ctl_model.send_pulses(1);
    cyc(4);
    chk("command", 32'h2, position_command_o);
    u_ctl_model.set_dir(1'b0);
    u_ctl_model.send_pulses(1);
    cyc(4);
    chk("command", 32'h3, position_command_o);
  endtask : t_pulse_gear
  task t_smoothing;
    chk("smoothed", 32'h3, smoothed_command_o);
    bw(gear_pkg::SMOOTH_OFS, 32'h3E9);
    rchk("smoothing", gear_pkg::SMOOTH_OFS, 32'h0);
    bw(gear_pkg::SMOOTH_OFS, 32'h1);
    u_ctl_model.send_pulses(1);
    cyc(10100);
    chk("smoothed", 32'h4, smoothed_command_o);
  endtask : t_smoothing
  task t_reg_move;
    int i;
    bw(gear_pkg::CTRL_OFS, 32'h4);
    bw(gear_pkg::NUM_FIRST_OFS, 32'h40);
    set_en(1'b1);
    bw(gear_pkg::NUM_FIRST_OFS, 32'h41);
    rchk("num_first", gear_pkg::NUM_FIRST_OFS, 32'h40);
    bw(gear_pkg::TABLE_OFS + 16'h0014, 32'h3E8);
    u_ctl_model.send_pulses(1);
    cyc(4);
    chk("command", 32'h0, position_command_o);
    u_ctl_model.start_move(6'h05);
    for (i = 0; i < 2000 && status_o.cmd_done !== 1'b1; i++) begin
      cyc(1);
    end
    if (i == 2000) begin
      failures++;
      test_done();
    end
    chk("command", 32'h3E8, position_command_o);
    motor_position_i <= 32'h3E8;
    cyc(5);
    chk("reached", 32'h1, {31'h0, status_o.target_reached});
    motor_position_i <= 32'h384;
    cyc(5);
    chk("reached", 32'h1, {31'h0, status_o.target_reached});
    chk("complete", 32'h1, {31'h0, status_o.motion_complete});
    motor_position_i <= 32'h383;
    cyc(5);
    chk("reached", 32'h0, {31'h0, status_o.target_reached});
    chk("complete", 32'h0, {31'h0, status_o.motion_complete});
    u_ctl_model.start_move(6'h05);
    cyc(2);
    chk("done", 32'h1, {31'h0, status_o.cmd_done});
    chk("command", 32'h3E8, position_command_o);
  endtask : t_reg_move
  task t_irq;
    bw(gear_pkg::IRQ_MASK_OFS, 32'h0);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq_o});
    rchk("irq_stat", gear_pkg::IRQ_STAT_OFS, 32'h7);
    bw(gear_pkg::IRQ_MASK_OFS, 32'h1);
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq_o});
    bw(gear_pkg::IRQ_STAT_OFS, 32'h1);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq_o});
  endtask : t_irq
  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  initial begin
    failures = 0;
    checks = 0;
    rst_i = 1'b1;
    bus_i = '0;
    drive_enable_i = 1'b0;
    motor_position_i = 32'h0;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_gear_access();
    set_en(1'b1);
    t_pulse_gear();
    t_smoothing();
    set_en(1'b0);
    t_reg_move();
    t_irq();
    test_done();
  end
endmodule : tb

// ==== verilog/gear_pkg.sv ====
// Package of constants and types for the position command gear block
package gear_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] SMOOTH_OFS = 16'h0110;
  localparam logic [15:0] NUM_FIRST_OFS = 16'h0158;
  localparam logic [15:0] DENOM_OFS = 16'h015A;
  localparam logic [15:0] NUM_EXTRA0_OFS = 16'h0278;
  localparam logic [15:0] NUM_EXTRA1_OFS = 16'h027C;
  localparam logic [15:0] NUM_EXTRA2_OFS = 16'h0280;
  localparam logic [15:0] BAND_OFS = 16'h016C;
  localparam logic [15:0] CTRL_OFS = 16'h0300;
  localparam logic [15:0] STATUS_OFS = 16'h0304;
  localparam logic [15:0] IRQ_STAT_OFS = 16'h0308;
  localparam logic [15:0] IRQ_MASK_OFS = 16'h030C;
  localparam logic [15:0] TABLE_OFS = 16'h0400;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [31:0] NUM_FIRST_RST = 32'h0000_0080;
  localparam logic [31:0] NUM_MAX = 32'h1FFF_FFFF;
  localparam logic [31:0] DENOM_RST = 32'h0000_000A;
  localparam logic [31:0] BAND_RST = 32'h0000_0064;
  localparam logic [15:0] SMOOTH_RST = 16'h0000;
  localparam logic [15:0] SMOOTH_MAX = 16'h03E8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int SMOOTH_STEP_MS = 10;
  localparam int SMOOTH_STEP_CYC = CLK_HZ / 1000 * SMOOTH_STEP_MS;
  localparam int SMOOTH_TICKS = 100;

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PULSE_MODE = 2'b01,
    REG_MODE = 2'b10
  } pos_mode_type;

  typedef enum logic [2:0] {
    PR_IDLE = 3'b001,
    PR_RUN = 3'b010,
    PR_DONE = 3'b100
  } pr_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic cmd_done;
    logic target_reached;
    logic motion_complete;
  } pos_status_type;

endpackage : gear_pkg

// ==== verilog/position_command_gear_and_status.sv ====
// Position command gear, smoothing filter and register position status
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
// Functional notes
// - Command rate is pulses times numerator over denominator
// - First numerator 32 bits, 1..2^29-1, resets 128
// - Extra numerators selectable as active numerator
// - Pulse mode: first numerator writable only when enabled
// - Register mode: first numerator writable only when disabled
// - Denominator write refused while drive enabled
// - Smoothing filter, 10 ms steps, zero disables
// - Select inputs and trigger choose stored command
// - Command done once selected command fully issued
// - Target reached when within band of target
// - Motion complete when done and target reached
module position_command_gear_and_status (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port
  input wire gear_pkg::bus_req_type bus_i,
  output logic [31:0] rdata_o,
  // Drive state
  input wire logic drive_enable_i,
  input wire logic [31:0] motor_position_i,
  // Controller pins
  input wire logic pulse_i,
  input wire logic pulse_dir_i,
  input wire logic [5:0] position_select_inputs_i,
  input wire logic command_trigger_input_i,
  // Command and status
  output logic [31:0] position_command_o,
  output logic [31:0] smoothed_command_o,
  output gear_pkg::pos_status_type status_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] pin_meta_reg;
  logic [8:0] pin_sync_reg;
  logic pulse_prev_reg;
  logic trig_prev_reg;
  logic pulse_rise;
  logic trig_rise;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_meta_reg <= 9'h000;
      pin_sync_reg <= 9'h000;
      pulse_prev_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {command_trigger_input_i, position_select_inputs_i, pulse_dir_i, pulse_i};
      pin_sync_reg <= pin_meta_reg;
      pulse_prev_reg <= pin_sync_reg[0];
      trig_prev_reg <= pin_sync_reg[8];
    end
  end

  assign pulse_rise = pin_sync_reg[0] & ~pulse_prev_reg;
  assign trig_rise = pin_sync_reg[8] & ~trig_prev_reg;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] num_first_reg;
  logic [31:0] num_extra_reg [3];
  logic [31:0] denom_reg;
  logic [31:0] band_reg;
  logic [15:0] smooth_reg;
  logic [1:0] num_sel_reg;
  gear_pkg::pos_mode_type mode_reg;
  logic [31:0] table_reg [64];
  logic num_first_ok;
  logic wr;
  logic [15:0] addr;

  assign wr = bus_i.wr;
  assign addr = bus_i.addr;
  assign num_first_ok = (mode_reg == gear_pkg::PULSE_MODE) ? drive_enable_i
                                                           : ~drive_enable_i;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      num_first_reg <= gear_pkg::NUM_FIRST_RST;
      denom_reg <= gear_pkg::DENOM_RST;
    end else if (wr) begin
      if (addr == gear_pkg::NUM_FIRST_OFS && num_first_ok && bus_i.wdata != 32'h0000_0000
          && bus_i.wdata <= gear_pkg::NUM_MAX) begin
        num_first_reg <= bus_i.wdata;
      end
      if (addr == gear_pkg::DENOM_OFS && !drive_enable_i && bus_i.wdata != 32'h0000_0000) begin
        denom_reg <= bus_i.wdata;
      end
    end
  end

  // Extra numerators
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      num_extra_reg[0] <= gear_pkg::NUM_FIRST_RST;
      num_extra_reg[1] <= gear_pkg::NUM_FIRST_RST;
      num_extra_reg[2] <= gear_pkg::NUM_FIRST_RST;
    end else if (wr) begin
      if (addr == gear_pkg::NUM_EXTRA0_OFS) begin
        num_extra_reg[0] <= bus_i.wdata;
      end
      if (addr == gear_pkg::NUM_EXTRA1_OFS) begin
        num_extra_reg[1] <= bus_i.wdata;
      end
      if (addr == gear_pkg::NUM_EXTRA2_OFS) begin
        num_extra_reg[2] <= bus_i.wdata;
      end
    end
  end

  // Band and smoothing setting
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      band_reg <= gear_pkg::BAND_RST;
      smooth_reg <= gear_pkg::SMOOTH_RST;
    end else if (wr) begin
      if (addr == gear_pkg::BAND_OFS) begin
        band_reg <= bus_i.wdata;
      end
      if (addr == gear_pkg::SMOOTH_OFS && bus_i.wdata[15:0] <= gear_pkg::SMOOTH_MAX) begin
        smooth_reg <= bus_i.wdata[15:0];
      end
    end
  end

  // Mode and numerator select
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      num_sel_reg <= 2'h0;
      mode_reg <= gear_pkg::PULSE_MODE;
    end else if (wr && addr == gear_pkg::CTRL_OFS) begin
      num_sel_reg <= bus_i.wdata[1:0];
      mode_reg <= bus_i.wdata[2] ? gear_pkg::REG_MODE : gear_pkg::PULSE_MODE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (wr && addr[15:8] == gear_pkg::TABLE_OFS[15:8] && addr[1:0] == 2'b00) begin
      table_reg[addr[7:2]] <= bus_i.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Electronic gear
  // ----------------------------------------------------------------
  logic [31:0] active_num;
  logic [31:0] remainder_reg;
  logic [31:0] gear_cmd_reg;
  logic [63:0] acc;
  logic [31:0] quot;
  logic [31:0] rem_next;

  assign active_num = (num_sel_reg == 2'h0) ? num_first_reg
                                            : num_extra_reg[num_sel_reg - 2'h1];
  assign acc = {32'h0000_0000, remainder_reg} + {32'h0000_0000, active_num};
  assign quot = 32'(acc / {32'h0000_0000, denom_reg});
  assign rem_next = 32'(acc % {32'h0000_0000, denom_reg});

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      remainder_reg <= 32'h0000_0000;
      gear_cmd_reg <= 32'h0000_0000;
    end else if (mode_reg == gear_pkg::PULSE_MODE && pulse_rise) begin
      remainder_reg <= rem_next;
      gear_cmd_reg <= pin_sync_reg[1] ? gear_cmd_reg - quot : gear_cmd_reg + quot;
    end
  end

  // ----------------------------------------------------------------
  // Register position sequencing
  // ----------------------------------------------------------------
  gear_pkg::pr_state_type pr_state_reg;
  logic [31:0] pr_target_reg;
  logic [31:0] pr_cmd_reg;
  logic [31:0] pr_diff;
  logic [31:0] pr_step;

  assign pr_diff = pr_target_reg - pr_cmd_reg;
  assign pr_step = pr_diff[31] ? -32'(quot) : quot;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pr_state_reg <= gear_pkg::PR_IDLE;
      pr_target_reg <= 32'h0000_0000;
      pr_cmd_reg <= 32'h0000_0000;
    end else if (mode_reg == gear_pkg::REG_MODE && trig_rise) begin
      pr_target_reg <= table_reg[pin_sync_reg[7:2]];
      pr_state_reg <= gear_pkg::PR_RUN;
    end else begin
      unique case (pr_state_reg)
        gear_pkg::PR_IDLE: begin
          pr_cmd_reg <= pr_cmd_reg;
        end
        gear_pkg::PR_RUN: begin
          if (pr_diff == 32'h0000_0000) begin
            pr_state_reg <= gear_pkg::PR_DONE;
          end else if ((pr_diff[31] ? -pr_diff : pr_diff) <= quot || quot == 32'h0000_0000) begin
            pr_cmd_reg <= pr_target_reg;
          end else begin
            pr_cmd_reg <= pr_cmd_reg + pr_step;
          end
        end
        gear_pkg::PR_DONE: begin
          pr_cmd_reg <= pr_cmd_reg;
        end
        default: begin
          pr_state_reg <= gear_pkg::PR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      position_command_o <= 32'h0000_0000;
    end else begin
      position_command_o <= (mode_reg == gear_pkg::REG_MODE) ? pr_cmd_reg : gear_cmd_reg;
    end
  end

  // ----------------------------------------------------------------
  // Smoothing filter
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_reg;
  logic [31:0] filt_err;
  logic [31:0] filt_div;
  logic [31:0] filt_step;

  assign filt_err = position_command_o - smoothed_command_o;
  assign filt_div = 32'({16'h0000, smooth_reg} * gear_pkg::SMOOTH_TICKS);
  assign filt_step = 32'($signed(filt_err) / $signed(filt_div));

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (tick_cnt_reg == 32'(gear_pkg::SMOOTH_STEP_CYC / gear_pkg::SMOOTH_TICKS - 1)) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      smoothed_command_o <= 32'h0000_0000;
    end else if (smooth_reg == 16'h0000) begin
      smoothed_command_o <= position_command_o;
    end else if (tick_cnt_reg == 32'h0000_0000) begin
      if (filt_step == 32'h0000_0000) begin
        smoothed_command_o <= position_command_o;
      end else begin
        smoothed_command_o <= smoothed_command_o + filt_step;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  logic [31:0] pos_err;
  logic [31:0] pos_err_abs;
  logic done_now;
  logic reach_now;

  assign pos_err = motor_position_i - pr_target_reg;
  assign pos_err_abs = pos_err[31] ? -pos_err : pos_err;
  assign done_now = (pr_state_reg == gear_pkg::PR_DONE);
  assign reach_now = (pos_err_abs <= band_reg);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_o <= '0;
    end else begin
      status_o.cmd_done <= done_now;
      status_o.target_reached <= reach_now;
      status_o.motion_complete <= done_now & reach_now;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_event;
  logic [2:0] irq_clear;

  assign irq_event = {done_now & reach_now & ~status_o.motion_complete,
                      reach_now & ~status_o.target_reached,
                      done_now & ~status_o.cmd_done};
  assign irq_clear = (wr && addr == gear_pkg::IRQ_STAT_OFS) ? bus_i.wdata[2:0] : 3'h0;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_event;
      if (wr && addr == gear_pkg::IRQ_MASK_OFS) begin
        irq_mask_reg <= bus_i.wdata[2:0];
      end
    end
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (bus_i.rd) begin
      unique case (addr)
        gear_pkg::SMOOTH_OFS: rdata_o <= {16'h0000, smooth_reg};
        gear_pkg::NUM_FIRST_OFS: rdata_o <= num_first_reg;
        gear_pkg::DENOM_OFS: rdata_o <= denom_reg;
        gear_pkg::NUM_EXTRA0_OFS: rdata_o <= num_extra_reg[0];
        gear_pkg::NUM_EXTRA1_OFS: rdata_o <= num_extra_reg[1];
        gear_pkg::NUM_EXTRA2_OFS: rdata_o <= num_extra_reg[2];
        gear_pkg::BAND_OFS: rdata_o <= band_reg;
        gear_pkg::CTRL_OFS: rdata_o <= {29'h0, mode_reg == gear_pkg::REG_MODE, num_sel_reg};
        gear_pkg::STATUS_OFS: rdata_o <= {29'h0, status_o};
        gear_pkg::IRQ_STAT_OFS: rdata_o <= {29'h0, irq_stat_reg};
        gear_pkg::IRQ_MASK_OFS: rdata_o <= {29'h0, irq_mask_reg};
        default: rdata_o <= (addr[15:8] == gear_pkg::TABLE_OFS[15:8]) ? table_reg[addr[7:2]]
                                                                      : 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule : position_command_gear_and_status
